// [design/sspr_pkg.sv]
// Constants and types for the serial status poll responder
package sspr_pkg;
  localparam logic [7:0] SSPR_REQ_BYTE = 8'h1e;
  localparam logic [7:0] SSPR_BUSY_BYTE = 8'hf7;
  localparam logic SSPR_POLL_EN_RST = 1'b1;
  localparam int SSPR_STAT_BIT = 7;
  localparam int SSPR_MODE_LSB = 4;
  localparam int SSPR_DIR_BIT = 3;
  localparam int SSPR_CLK_MHZ = 200;
  localparam int SSPR_MODE_LAT_MS = 20;
  localparam int SSPR_MODE_LAT_CYC = SSPR_MODE_LAT_MS * SSPR_CLK_MHZ * 1000;

  localparam logic [2:0] SSPR_ST_ERROR = 3'h0;
  localparam logic [2:0] SSPR_ST_REQUEST = 3'h1;
  localparam logic [2:0] SSPR_ST_TRAFFIC = 3'h2;
  localparam logic [2:0] SSPR_ST_IDLE = 3'h3;
  localparam logic [2:0] SSPR_ST_OVER = 3'h4;
  localparam logic [2:0] SSPR_ST_PHASING = 3'h5;
  localparam logic [2:0] SSPR_ST_SYNC = 3'h6;
  localparam logic [2:0] SSPR_ST_UNDEF = 3'h7;

  localparam logic [2:0] SSPR_MD_STANDBY = 3'h0;
  localparam logic [2:0] SSPR_MD_LEGACY_ARQ = 3'h1;
  localparam logic [2:0] SSPR_MD_PRIMARY_ARQ = 3'h2;
  localparam logic [2:0] SSPR_MD_LEGACY_BC = 3'h3;
  localparam logic [2:0] SSPR_MD_PRIMARY_BC = 3'h4;
  localparam logic [2:0] SSPR_MD_TELEPRINTER = 3'h5;
  localparam logic [2:0] SSPR_MD_LISTEN = 3'h6;
  localparam logic [2:0] SSPR_MD_BUSY = 3'h7;

  typedef enum logic [2:0] {
    SSPR_IDLE_S = 3'b001,
    SSPR_HDR_S = 3'b010,
    SSPR_STAT_S = 3'b100
  } sspr_state_t;
endpackage : sspr_pkg

// [design/sspr_status_encoder.sv]
// Status byte encoder from mode and link conditions
`timescale 1ns/1ps
`default_nettype none
module sspr_status_encoder
  import sspr_pkg::*;
(
  input wire logic [2:0] op_mode,
  input wire logic sender_indicator,
  input wire logic chan_busy,
  input wire logic link_error,
  input wire logic link_request,
  input wire logic link_traffic,
  input wire logic pkt_has_idle,
  input wire logic changeover,
  input wire logic phasing,
  input wire logic synchronizing_state,
  output logic [7:0] status_byte
);
  logic [2:0] code;
  always_comb begin
    if (synchronizing_state) begin
      code = SSPR_ST_SYNC;
    end else if (phasing && op_mode == SSPR_MD_LEGACY_ARQ) begin
      code = SSPR_ST_PHASING;
    end else if (changeover) begin
      code = SSPR_ST_OVER;
    end else if (pkt_has_idle) begin
      code = SSPR_ST_IDLE;
    end else if (link_traffic) begin
      code = SSPR_ST_TRAFFIC;
    end else if (link_request) begin
      code = SSPR_ST_REQUEST;
    end else if (link_error) begin
      code = SSPR_ST_ERROR;
    end else begin
      code = SSPR_ST_UNDEF;
    end
    if (op_mode == SSPR_MD_STANDBY && chan_busy) begin
      status_byte = SSPR_BUSY_BYTE;
    end else begin
      // Mode in 6..4, direction in 3, bit 7 forced high
      status_byte = {1'b1, op_mode, sender_indicator, code};
    end
  end
endmodule : sspr_status_encoder
`default_nettype wire

// [design/sspr_responder.sv]
// Serial status poll responder top
`timescale 1ns/1ps
`default_nettype none
module sspr_responder
  import sspr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  input wire logic poll_enable,
  input wire logic prompt_issued,
  input wire logic flow_stopped,
  input wire logic [2:0] op_mode,
  input wire logic sender_indicator,
  input wire logic chan_busy,
  input wire logic link_error,
  input wire logic link_request,
  input wire logic link_traffic,
  input wire logic pkt_has_idle,
  input wire logic changeover,
  input wire logic phasing,
  input wire logic synchronizing_state,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic pass_valid,
  output logic [7:0] pass_data,
  output logic reply_busy,
  output logic [7:0] link_status_byte
);
  ////////////////////////////////////////////////////////////////////////
  sspr_state_t state_r, state_nxt;
  logic ready_r, ready_nxt;
  logic tx_valid_r, tx_valid_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic [7:0] snap_r, snap_nxt;
  logic pass_valid_r, pass_valid_nxt;
  logic [7:0] pass_data_r, pass_data_nxt;
  logic [7:0] live_status;
  logic [7:0] live_r;
  logic is_req;
  logic reply_busy_r, reply_busy_nxt;

  sspr_status_encoder u_enc (
    .op_mode(op_mode),
    .sender_indicator(sender_indicator),
    .chan_busy(chan_busy),
    .link_error(link_error),
    .link_request(link_request),
    .link_traffic(link_traffic),
    .pkt_has_idle(pkt_has_idle),
    .changeover(changeover),
    .phasing(phasing),
    .synchronizing_state(synchronizing_state),
    .status_byte(live_status)
  );

  // Flow control deliberately unused in the request path
  assign is_req = rx_valid && rx_data == SSPR_REQ_BYTE && poll_enable && ready_r;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    ready_nxt = ready_r | prompt_issued;
    tx_valid_nxt = tx_valid_r;
    tx_data_nxt = tx_data_r;
    snap_nxt = snap_r;
    pass_valid_nxt = 1'b0;
    pass_data_nxt = pass_data_r;
    // Non-poll bytes, or polls while disabled or not ready, flow on
    if (rx_valid && !is_req && !(state_r != SSPR_IDLE_S && rx_data == SSPR_REQ_BYTE
        && poll_enable && ready_r)) begin
      pass_valid_nxt = 1'b1;
      pass_data_nxt = rx_data;
    end
    case (state_r)
      SSPR_IDLE_S: begin
        if (is_req) begin
          snap_nxt = live_status;
          tx_valid_nxt = 1'b1;
          tx_data_nxt = SSPR_REQ_BYTE;
          state_nxt = SSPR_HDR_S;
        end
      end
      SSPR_HDR_S: begin
        // Requests arriving here are dropped
        if (tx_ready) begin
          tx_data_nxt = snap_r;
          state_nxt = SSPR_STAT_S;
        end
      end
      SSPR_STAT_S: begin
        if (tx_ready) begin
          tx_valid_nxt = 1'b0;
          state_nxt = SSPR_IDLE_S;
        end
      end
      default: begin
        state_nxt = SSPR_IDLE_S;
        tx_valid_nxt = 1'b0;
      end
    endcase
    // Registered so the busy output never glitches on state decode
    reply_busy_nxt = (state_nxt != SSPR_IDLE_S);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= SSPR_IDLE_S;
      ready_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      snap_r <= 8'h00;
      pass_valid_r <= 1'b0;
      pass_data_r <= 8'h00;
      live_r <= 8'h00;
      reply_busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
      tx_valid_r <= tx_valid_nxt;
      tx_data_r <= tx_data_nxt;
      snap_r <= snap_nxt;
      pass_valid_r <= pass_valid_nxt;
      pass_data_r <= pass_data_nxt;
      live_r <= live_status;
      reply_busy_r <= reply_busy_nxt;
    end
  end

  assign tx_valid = tx_valid_r;
  assign tx_data = tx_data_r;
  assign pass_valid = pass_valid_r;
  assign pass_data = pass_data_r;
  assign reply_busy = reply_busy_r;
  assign link_status_byte = live_r;

  ////////////////////////////////////////////////////////////////////////
  property p_hdr_first;
    @(posedge clock) disable iff (!rst_n)
      is_req && state_r == SSPR_IDLE_S |=> tx_valid && tx_data == 8'h1e;
  endproperty
  a_hdr_first: assert property (p_hdr_first) else $error("header not echoed");

  property p_b2b;
    @(posedge clock) disable iff (!rst_n)
      state_r == SSPR_HDR_S && tx_ready |=> state_r == SSPR_STAT_S && tx_valid
        && tx_data == $past(snap_r);
  endproperty
  a_b2b: assert property (p_b2b) else $error("status not right after header");

  property p_no_prompt;
    @(posedge clock) disable iff (!rst_n)
      !ready_r && state_r == SSPR_IDLE_S |=> state_r == SSPR_IDLE_S;
  endproperty
  a_no_prompt: assert property (p_no_prompt) else $error("reply before prompt");

  property p_disabled;
    @(posedge clock) disable iff (!rst_n)
      rx_valid && !poll_enable |=> pass_valid && pass_data == $past(rx_data);
  endproperty
  a_disabled: assert property (p_disabled) else $error("poll byte not passed");

  property p_bit7;
    @(posedge clock) disable iff (!rst_n)
      state_r == SSPR_STAT_S |-> tx_data[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("status bit 7 low");

  property p_snap;
    @(posedge clock) disable iff (!rst_n)
      state_r == SSPR_STAT_S && !tx_ready |=> tx_data == $past(tx_data);
  endproperty
  a_snap: assert property (p_snap) else $error("status changed mid reply");

  property p_drop;
    @(posedge clock) disable iff (!rst_n)
      state_r != SSPR_IDLE_S && rx_valid && rx_data == 8'h1e && poll_enable && ready_r
        |=> !pass_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("request during reply leaked");

  property p_flow;
    @(posedge clock) disable iff (!rst_n)
      is_req && state_r == SSPR_IDLE_S && flow_stopped |=> state_r == SSPR_HDR_S;
  endproperty
  a_flow: assert property (p_flow) else $error("flow control blocked reply");

  property p_busy;
    @(posedge clock) disable iff (!rst_n)
      op_mode == SSPR_MD_STANDBY && chan_busy |=> link_status_byte == 8'hf7;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not 247");

  property p_dir;
    @(posedge clock) disable iff (!rst_n)
      !(op_mode == SSPR_MD_STANDBY && chan_busy) |=>
        link_status_byte[3] == $past(sender_indicator);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit wrong");

  // Field checks on the live encoder output, same cycle as its inputs
  property p_mode_field;
    @(posedge clock) disable iff (!rst_n)
      !(op_mode == SSPR_MD_STANDBY && chan_busy) |-> live_status[6:4] == op_mode;
  endproperty
  a_mode_field: assert property (p_mode_field) else $error("mode field wrong");

  property p_sync_now;
    @(posedge clock) disable iff (!rst_n)
      synchronizing_state && !(op_mode == SSPR_MD_STANDBY && chan_busy)
        |-> live_status[2:0] == SSPR_ST_SYNC;
  endproperty
  a_sync_now: assert property (p_sync_now) else $error("sync code late");

  property p_over_wins;
    @(posedge clock) disable iff (!rst_n)
      changeover && !synchronizing_state && !(phasing && op_mode == SSPR_MD_LEGACY_ARQ)
        && !(op_mode == SSPR_MD_STANDBY && chan_busy) |-> live_status[2:0] == SSPR_ST_OVER;
  endproperty
  a_over_wins: assert property (p_over_wins) else $error("changeover not reported");

  property p_idle_wins;
    @(posedge clock) disable iff (!rst_n)
      pkt_has_idle && !changeover && !synchronizing_state
        && !(phasing && op_mode == SSPR_MD_LEGACY_ARQ)
        && !(op_mode == SSPR_MD_STANDBY && chan_busy) |-> live_status[2:0] == SSPR_ST_IDLE;
  endproperty
  a_idle_wins: assert property (p_idle_wins) else $error("idle not reported");

  property p_phase_legacy;
    @(posedge clock) disable iff (!rst_n)
      live_status[2:0] == SSPR_ST_PHASING |-> op_mode == SSPR_MD_LEGACY_ARQ;
  endproperty
  a_phase_legacy: assert property (p_phase_legacy) else $error("phasing outside legacy");

  c_reply: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == SSPR_HDR_S ##1 state_r == SSPR_STAT_S ##1 state_r == SSPR_IDLE_S);
  c_drop: cover property (@(posedge clock) disable iff (!rst_n)
    state_r == SSPR_HDR_S && rx_valid && rx_data == 8'h1e);
  c_busy: cover property (@(posedge clock) disable iff (!rst_n)
    is_req && chan_busy && op_mode == SSPR_MD_STANDBY);
endmodule : sspr_responder
`default_nettype wire

// [verification/sspr_host_model.sv]
// Host terminal model that polls the responder over the serial link
`timescale 1ns/1ps
`default_nettype none
module sspr_host_model (
  input wire logic clock,
  input wire logic send_valid,
  input wire logic [7:0] send_data,
  input wire logic slow,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic [1:0] cnt_r = 2'h0;
  ////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    rx_valid <= send_valid;
    // Idle line shows inverted byte so stale data never matches
    rx_data <= send_valid ? send_data : ~send_data;
    cnt_r <= cnt_r + 2'h1;
    // Slow host takes one byte in four, as a late reader would
    tx_ready <= !slow || cnt_r == 2'h0;
  end
endmodule : sspr_host_model
`default_nettype wire

// [verification/sspr_responder_test.sv]
// Self-checking bench for the status poll responder
`timescale 1ns/1ps
`default_nettype none
module sspr_responder_test;
  import sspr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic send_valid = 1'b0;
  logic [7:0] send_data = 8'h00;
  logic slow = 1'b0;
  logic poll_enable = 1'b1;
  logic prompt_issued = 1'b0;
  logic flow_stopped = 1'b0;
  logic [2:0] op_mode = 3'h0;
  logic sender_indicator = 1'b0;
  logic chan_busy = 1'b0;
  logic [6:0] cond = 7'h00;
  logic rx_valid, tx_ready, tx_valid, pass_valid, reply_busy;
  logic [7:0] rx_data, tx_data, pass_data, link_status_byte;
  logic [7:0] q[$];
  logic [7:0] pq[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  always #2.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////
  sspr_host_model sspr_host_model_i (.clock(clock), .send_valid(send_valid),
    .send_data(send_data), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready));
  sspr_responder sspr_responder_i (.clock(clock), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_ready(tx_ready), .poll_enable(poll_enable),
    .prompt_issued(prompt_issued), .flow_stopped(flow_stopped), .op_mode(op_mode),
    .sender_indicator(sender_indicator), .chan_busy(chan_busy), .link_error(cond[0]),
    .link_request(cond[1]), .link_traffic(cond[2]), .pkt_has_idle(cond[3]),
    .changeover(cond[4]), .phasing(cond[5]), .synchronizing_state(cond[6]),
    .tx_valid(tx_valid), .tx_data(tx_data), .pass_valid(pass_valid),
    .pass_data(pass_data), .reply_busy(reply_busy), .link_status_byte(link_status_byte));
  always @(posedge clock) begin
    if (tx_valid && tx_ready) q.push_back(tx_data);
    if (tx_valid) cmp8(8'(reply_busy), 8'h01);
    if (pass_valid) pq.push_back(pass_data);
  end
  ////////////////////////////////////////////////////////////////
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic results();
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // Sends ns copies of b; flip alters the mode once the request is taken
  task automatic xfer(input logic [7:0] b, input int ns, input int ntx, input int np,
    input logic [2:0] flip);
    int i;
    q.delete();
    pq.delete();
    @(posedge clock);
    send_valid <= 1'b1;
    send_data <= b;
    repeat (ns) @(posedge clock);
    send_valid <= 1'b0;
    @(posedge clock);
    op_mode <= op_mode ^ flip;
    for (i = 0; i < 60 && (q.size() < ntx || pq.size() < np); i++) @(posedge clock);
    if (i == 60) begin
      n_mismatch++;
      results();
    end
    repeat (6) @(posedge clock);
    cmp8(8'(q.size()), 8'(ntx));
    cmp8(8'(pq.size()), 8'(np));
  endtask : xfer
  task automatic poll(input logic [7:0] exp, input logic [2:0] flip);
    repeat (2) @(posedge clock);
    cmp8(link_status_byte, exp);
    xfer(SSPR_REQ_BYTE, 1, 2, 0, flip);
    cmp8(8'(reply_busy), 8'h00);
    cmp8(q[0], 8'h1e);
    cmp8(q[1], exp);
  endtask : poll
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    xfer(8'h1e, 1, 0, 1, 3'h0);
    prompt_issued <= 1'b1;
    @(posedge clock);
    prompt_issued <= 1'b0;
    xfer(8'h41, 1, 0, 1, 3'h0);
    cmp8(pq[0], 8'h41);
    for (int m = 0; m < 8; m++) begin
      op_mode <= 3'(m);
      sender_indicator <= m[0];
      poll({1'b1, 3'(m), m[0], 3'h7}, 3'h0);
    end
    op_mode <= SSPR_MD_LEGACY_ARQ;
    sender_indicator <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      cond <= 7'h01 << k;
      poll({4'h9, 1'b0, 3'(k)}, 3'h0);
    end
    cond <= 7'h0c;
    poll(8'h93, 3'h0);
    cond <= 7'h1d;
    poll(8'h94, 3'h0);
    op_mode <= SSPR_MD_PRIMARY_ARQ;
    cond <= 7'h20;
    poll(8'ha7, 3'h0);
    op_mode <= SSPR_MD_STANDBY;
    cond <= 7'h00;
    chan_busy <= 1'b1;
    poll(8'hf7, 3'h0);
    chan_busy <= 1'b0;
    flow_stopped <= 1'b1;
    slow <= 1'b1;
    // Stalled host, mode changes mid-reply: reply keeps the old mode
    poll(8'h87, 3'h2);
    xfer(8'h1e, 2, 2, 0, 3'h0);
    cmp8(q[1], 8'ha7);
    slow <= 1'b0;
    flow_stopped <= 1'b0;
    poll_enable <= 1'b0;
    xfer(8'h1e, 1, 0, 1, 3'h0);
    poll_enable <= 1'b1;
    rst_n <= 1'b0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    xfer(8'h1e, 1, 0, 1, 3'h0);
    results();
  end
endmodule : sspr_responder_test
`default_nettype wire
